// ### design/uimg_defs.svh
// Constants of the UART interrupt mask gate: offsets, field positions, resets.
// Assumes inclusion by bare name from every design file that needs them.
//
// Overview of operation
// - A read of the interrupt mask register returns the mask now held for each source.
// - A mask bit written to one lets its raw interrupt condition reach the controller.
// - A mask bit written to zero keeps its raw interrupt condition from the controller.
// - Bits 31 to 11 are reserved, read as zero, and software keeps them on read-modify-write.
// - Bit 10 is the overrun error mask, read-write, zero after reset.
// - Bit 9 is the break error mask, read-write, zero after reset.
// - Bit 8 is the parity error mask, read-write, zero after reset.
// - Bit 7 is the framing error mask, read-write, zero after reset.
// - Bit 6 is the receive time-out mask, read-write, zero after reset.
`ifndef UIMG_DEFS_SVH
`define UIMG_DEFS_SVH

`define UIMG_ADDR_W      12
`define UIMG_OFF_MASK    12'h038
`define UIMG_OFF_RAW     12'h03C
`define UIMG_OFF_MSKD    12'h040

`define UIMG_NSRC        5
`define UIMG_FIELD_LSB   6
`define UIMG_FIELD_MSB   10
`define UIMG_BIT_RTO     6
`define UIMG_BIT_FRM     7
`define UIMG_BIT_PAR     8
`define UIMG_BIT_BRK     9
`define UIMG_BIT_OVR     10
`define UIMG_RSVD_LSB    11

`define UIMG_MASK_RST    5'h00
`define UIMG_RAW_RST     5'h00

`define UIMG_HTRANS_NSEQ 2'h2
`define UIMG_HSIZE_WORD  3'h2

`endif

// ### design/uimg_pkg.sv
// Types of the UART interrupt mask gate.
// Assumes the constants header is on the include path.
`include "uimg_defs.svh"
`default_nettype none

package uimg_pkg;

  typedef logic [`UIMG_NSRC-1:0] uimg_src_t;

  typedef enum logic [3:0] {
    UIMG_ST_IDLE  = 4'h1,
    UIMG_ST_WDATA = 4'h2,
    UIMG_ST_RWAIT = 4'h4,
    UIMG_ST_RDATA = 4'h8
  } uimg_state_t;

endpackage : uimg_pkg

`default_nettype wire

// ### design/uimg_irq_if.sv
// Interface carrying the sticky raw conditions and masks into the gate.
// Assumes one producer (the register block) and one gate.
`default_nettype none

interface uimg_irq_if #(
  parameter int NSRC = 5
);
  logic [NSRC-1:0] raw;
  logic [NSRC-1:0] mask;
  logic [NSRC-1:0] masked;
  logic            req;

  modport regs (output raw, output mask, input masked, input req);
  modport gate (input raw, input mask, output masked, output req);
endinterface : uimg_irq_if

`default_nettype wire

// ### design/uimg_mask_gate.sv
// Gate that ANDs each raw condition with its mask and ORs the results.
// Assumes raw and mask come from flip-flops of the same clock.
`default_nettype none

module uimg_mask_gate #(
  parameter int NSRC = 5
) (
  uimg_irq_if.gate irq
);
  import uimg_pkg::*;

  genvar i;
  generate
    for (i = 0; i < NSRC; i++) begin : g_src
      assign irq.masked[i] = irq.raw[i] & irq.mask[i];
    end
  endgenerate

  assign irq.req = |irq.masked;

endmodule : uimg_mask_gate

`default_nettype wire

// ### design/uimg_top.sv
// AHB-Lite slave holding the UART interrupt mask, the sticky raw status
// and the masked view, with one level interrupt request to the controller.
// Assumes raw events are one-cycle pulses from UART logic on hclk.
`include "uimg_defs.svh"
`default_nettype none

module uimg_top #(
  parameter int NSRC = `UIMG_NSRC
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire uimg_pkg::uimg_src_t raw_event,
  output uimg_pkg::uimg_src_t     masked_irq,
  output logic                    uart_irq
);
  import uimg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus state and address capture.

  uimg_state_t                state_reg;
  uimg_state_t                state_next;
  logic [`UIMG_ADDR_W-1:0]    addr_reg;
  logic [`UIMG_ADDR_W-1:0]    addr_next;
  logic [31:0]                hrdata_reg;
  logic [31:0]                hrdata_next;
  logic [NSRC-1:0]            mask_reg;
  logic [NSRC-1:0]            mask_next;
  logic [NSRC-1:0]            raw_reg;
  logic [NSRC-1:0]            raw_next;

  wire                        bus_ready;
  wire                        req_valid;
  wire                        req_write;
  wire                        req_read;
  wire                        in_wdata;
  wire                        sel_mask;
  wire                        sel_raw;
  wire                        sel_mskd;
  wire                        wr_mask;
  wire                        wr_raw;
  wire [NSRC-1:0]             wr_field;
  wire [NSRC-1:0]             raw_clear;
  wire [31:0]                 rd_value;

  uimg_irq_if #(.NSRC(NSRC)) irq_bus ();

  // A transfer is taken only while the bus shows ready, so the wait state
  // of a read also holds off the next address phase.
  assign bus_ready = hready & hreadyout;
  assign req_valid = hsel & bus_ready & htrans[1];
  assign req_write = req_valid & hwrite & (hsize == `UIMG_HSIZE_WORD);
  assign req_read  = req_valid & ~hwrite;
  assign in_wdata  = (state_reg == UIMG_ST_WDATA);

  assign sel_mask  = (addr_reg == `UIMG_OFF_MASK);
  assign sel_raw   = (addr_reg == `UIMG_OFF_RAW);
  assign sel_mskd  = (addr_reg == `UIMG_OFF_MSKD);
  assign wr_mask   = in_wdata & sel_mask;
  assign wr_raw    = in_wdata & sel_raw;
  assign wr_field  = hwdata[`UIMG_FIELD_MSB:`UIMG_FIELD_LSB];
  assign raw_clear = wr_raw ? wr_field : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencing.

  always_comb begin
    state_next = state_reg;
    addr_next  = addr_reg;
    case (state_reg)
      UIMG_ST_IDLE, UIMG_ST_WDATA, UIMG_ST_RDATA: begin
        state_next = UIMG_ST_IDLE;
        if (req_write) begin
          state_next = UIMG_ST_WDATA;
          addr_next  = haddr[`UIMG_ADDR_W-1:0];
        end else if (req_read) begin
          state_next = UIMG_ST_RWAIT;
          addr_next  = haddr[`UIMG_ADDR_W-1:0];
        end
      end
      UIMG_ST_RWAIT: begin
        state_next = UIMG_ST_RDATA;
      end
      default: begin
        state_next = UIMG_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= UIMG_ST_IDLE;
      addr_reg  <= '0;
    end else begin
      state_reg <= state_next;
      addr_reg  <= addr_next;
    end
  end

  // The wait state lets a write taken just before land before the read
  // value is sampled.
  assign hreadyout = (state_reg != UIMG_ST_RWAIT);
  assign hresp     = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Mask and raw status registers.

  // Only bits 10 to 6 are stored; everything else written is dropped.
  assign mask_next = wr_mask ? wr_field : mask_reg;

  // A new event beats a clear arriving in the same cycle.
  assign raw_next  = (raw_reg & ~raw_clear) | raw_event;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_reg <= `UIMG_MASK_RST;
      raw_reg  <= `UIMG_RAW_RST;
    end else begin
      mask_reg <= mask_next;
      raw_reg  <= raw_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path.

  // Reserved bits above the field and below it read as zero.
  assign rd_value = sel_mask ? {21'h0, mask_reg, 6'h0} :
                    sel_raw  ? {21'h0, raw_reg, 6'h0} :
                    sel_mskd ? {21'h0, irq_bus.masked, 6'h0} :
                               32'h0000_0000;

  assign hrdata_next = (state_reg == UIMG_ST_RWAIT) ? rd_value : hrdata_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else begin
      hrdata_reg <= hrdata_next;
    end
  end

  assign hrdata = hrdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Gate toward the interrupt controller.

  assign irq_bus.raw  = raw_reg;
  assign irq_bus.mask = mask_reg;

  uimg_mask_gate #(
    .NSRC (NSRC)
  ) u_gate (
    .irq (irq_bus.gate)
  );

  assign masked_irq = irq_bus.masked;
  assign uart_irq   = irq_bus.req;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  AST_READ_MASK: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == UIMG_ST_RWAIT) && sel_mask && !wr_mask
      |=> hrdata[`UIMG_FIELD_MSB:`UIMG_FIELD_LSB] == $past(mask_reg)
  ) else $error("mask read does not return the held mask");

  AST_WRITE_ONE_PASSES: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_mask && hwdata[`UIMG_BIT_OVR] ##1 raw_reg[4] && !wr_mask
      |-> masked_irq[4] && uart_irq
  ) else $error("overrun condition not passed after mask set");

  AST_WRITE_ZERO_BLOCKS: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_mask && (wr_field == 5'h00) |=> !uart_irq && (masked_irq == 5'h00)
  ) else $error("request raised with every mask cleared");

  AST_RSVD_ZERO: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == UIMG_ST_RDATA)
      |-> (hrdata[31:`UIMG_RSVD_LSB] == 21'h0) && (hrdata[5:0] == 6'h0)
  ) else $error("reserved read bits not zero");

  AST_OVR_BIT: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_mask |=> mask_reg[4] == $past(hwdata[`UIMG_BIT_OVR])
  ) else $error("overrun mask bit not stored from bit 10");

  AST_BRK_BIT: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_mask |=> mask_reg[3] == $past(hwdata[`UIMG_BIT_BRK])
  ) else $error("break mask bit not stored from bit 9");

  AST_PAR_BIT: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_mask |=> mask_reg[2] == $past(hwdata[`UIMG_BIT_PAR])
  ) else $error("parity mask bit not stored from bit 8");

  AST_FRM_BIT: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_mask |=> mask_reg[1] == $past(hwdata[`UIMG_BIT_FRM])
  ) else $error("framing mask bit not stored from bit 7");

  AST_RTO_BIT: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_mask |=> mask_reg[0] == $past(hwdata[`UIMG_BIT_RTO])
  ) else $error("time-out mask bit not stored from bit 6");

  AST_MASK_HOLDS: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !wr_mask |=> $stable(mask_reg)
  ) else $error("mask changed without a write");

  AST_GATE_AND_OR: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (masked_irq == (raw_reg & mask_reg)) && (uart_irq == |(raw_reg & mask_reg))
  ) else $error("masked outputs do not follow raw and mask");

  AST_SET_BEATS_CLEAR: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_raw && raw_event[0] |=> raw_reg[0]
  ) else $error("event lost against a clear");

  AST_READ_WAIT_ONE: assert property (
    @(posedge hclk) disable iff (!hresetn)
    req_read |=> !hreadyout ##1 hreadyout
  ) else $error("read wait state is not exactly one cycle");

endmodule : uimg_top

`default_nettype wire

// ### tb/uimg_intc_model.sv
// Model of the interrupt controller that takes the UART request line.
// Assumes uart_irq is a level on hclk and irq_ack is a one-cycle pulse.
`default_nettype none

module uimg_intc_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic uart_irq,
  input  wire logic irq_ack,
  output var  logic irq_pending
);
  timeunit 1ns;
  timeprecision 1ps;

  // A request that is still high wins over an acknowledge.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_pending <= 1'b0;
    end else if (uart_irq) begin
      irq_pending <= 1'b1;
    end else if (irq_ack) begin
      irq_pending <= 1'b0;
    end
  end
endmodule : uimg_intc_model

`default_nettype wire

// ### tb/uart_interrupt_mask_gate_bench.sv
// Bench of the UART interrupt mask gate: AHB-Lite master tasks and tests.
// Assumes the design files and the controller model are compiled first.
`include "uimg_defs.svh"
`default_nettype none

module uart_interrupt_mask_gate_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import uimg_pkg::*;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  uimg_src_t   raw_event;
  uimg_src_t   masked_irq;
  logic        uart_irq;
  logic        irq_ack;
  logic        irq_pending;
  logic [31:0] rd_s;
  int          miscompares;
  int          samples_checked;
  int          cycles;

  uimg_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .raw_event(raw_event), .masked_irq(masked_irq),
    .uart_irq(uart_irq));

  uimg_intc_model intc (.hclk(hclk), .hresetn(hresetn), .uart_irq(uart_irq),
    .irq_ack(irq_ack), .irq_pending(irq_pending));

  ////////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Ready is stable from the falling edge, so it is judged there for the next rise.
  task automatic wait_ready();
    do @(negedge hclk); while (hreadyout !== 1'b1);
    rd_s = hrdata;
    @(posedge hclk);
  endtask : wait_ready

  task automatic xfer(input logic [31:0] a, input logic w, input logic [2:0] sz,
                      input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= `UIMG_HTRANS_NSEQ;
    hwrite <= w;
    hsize  <= sz;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(a, 1'b1, `UIMG_HSIZE_WORD, d);
  endtask : wr

  task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, `UIMG_HSIZE_WORD, 32'h0000_0000);
    check(name, exp, rd_s);
    check("hresp", 32'h0000_0000, 32'(hresp));
  endtask : rd_chk

  task automatic pulse(input uimg_src_t ev);
    raw_event <= ev;
    @(posedge hclk);
    raw_event <= '0;
    @(posedge hclk);
  endtask : pulse

  task automatic chk_irq(input string name, input uimg_src_t exp);
    @(negedge hclk);
    check(name, 32'(exp), 32'(masked_irq));
    check("uart_irq", 32'(exp != '0), 32'(uart_irq));
    @(posedge hclk);
  endtask : chk_irq

  ////////////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = `UIMG_HSIZE_WORD;
    hwdata = 32'h0000_0000;
    raw_event = '0;
    irq_ack = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("mask rst", `UIMG_OFF_MASK, 32'h0000_0000);
    rd_chk("raw reset", `UIMG_OFF_RAW, 32'h0000_0000);
    $display("test reset done");
    wr(`UIMG_OFF_MASK, 32'hFFFF_FFFF);
    rd_chk("mask ones", `UIMG_OFF_MASK, 32'h0000_07C0);
    chk_irq("mask no raw", 5'h00);
    pulse(5'h10);
    chk_irq("overrun", 5'h10);
    // The event is held through the clearing write, so it must survive it.
    raw_event <= 5'h01;
    wr(`UIMG_OFF_RAW, 32'h0000_07C0);
    raw_event <= 5'h00;
    chk_irq("set beats clear", 5'h01);
    wr(`UIMG_OFF_RAW, 32'h0000_07C0);
    chk_irq("raw cleared", 5'h00);
    $display("test reserved done");
    for (int i = 0; i < `UIMG_NSRC; i++) begin
      pulse('1);
      xfer(`UIMG_OFF_MASK, 1'b0, `UIMG_HSIZE_WORD, 32'h0000_0000);
      rd_s = rd_s & 32'hFFFF_F83F;
      wr(`UIMG_OFF_MASK, rd_s | (32'h0000_0040 << i));
      chk_irq("one source", uimg_src_t'(1 << i));
      rd_chk("mask back", `UIMG_OFF_MASK, 32'h0000_0040 << i);
      rd_chk("masked stat", `UIMG_OFF_MSKD, 32'h0000_0040 << i);
      check("pending", 32'h0000_0001, 32'(irq_pending));
      wr(`UIMG_OFF_MASK, 32'h0000_0000);
      chk_irq("masked off", 5'h00);
      wr(`UIMG_OFF_RAW, 32'h0000_07C0);
    end
    irq_ack <= 1'b1;
    @(posedge hclk);
    irq_ack <= 1'b0;
    chk_irq("after ack", 5'h00);
    check("pending ack", 32'h0000_0000, 32'(irq_pending));
    $display("test gating done");
    wr(32'h0000_0100, 32'hFFFF_FFFF);
    rd_chk("unmapped", 32'h0000_0100, 32'h0000_0000);
    xfer(`UIMG_OFF_MASK, 1'b1, 3'h0, 32'h0000_07C0);
    rd_chk("byte write", `UIMG_OFF_MASK, 32'h0000_0000);
    $display("test refusals done");
    wr(`UIMG_OFF_MASK, 32'hFFFF_FFFF);
    pulse('1);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_irq("irq after reset", 5'h00);
    rd_chk("mask after reset", `UIMG_OFF_MASK, 32'h0000_0000);
    rd_chk("raw after reset", `UIMG_OFF_RAW, 32'h0000_0000);
    $display("test mid reset done");
    give_verdict();
  end
endmodule : uart_interrupt_mask_gate_bench

`default_nettype wire
